// >>> rtl/adc_ctrl_top.sv
// converter control: divider, result bytes, read lock, auto trigger
//
// Behaviour
// - converter clock is system clock divided by 2,2,4,8..128 per select
// - right aligned: result 9:8 in high byte bits 1:0, 7:0 in low
// - left aligned: result 9:2 in high byte, 1:0 in low bits 7:6
// - each finished conversion is stored into the result bytes unless the read lock is set
// - reading low byte freezes both result bytes until high is read
// - result bytes are read only and reset to zero
// - trigger select matters only while auto trigger is enabled
// - auto trigger starts a conversion on each rising selected flag seen while idle
// - switching from a clear source to a set one is an edge
// - switching to free running never produces a trigger
// - trigger codes: free, comparator, int0, t0 cmpA, t0 ovf, t1 ...
// - set input disable bit blanks the digital pin read to zero
// - auto trigger enable starts conversions on trigger edges
// - done flag sets on completion; clears on vector entry or write one
// - start reads one while busy; first conversion 25 clocks, then 13
// - alignment change takes effect on the result bytes at once
`include "adc_ctrl_params.svh"
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_top (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic [9:0] sampleData,
   input wire adc_ctrl_pkg::trig_flags_s trigFlags,
   input wire logic vectorAck,
   input wire logic [7:0] pinLevel,
   output logic [7:0] pinRead,
   output logic [7:0] inputBufferOff,
   output logic convBusy,
   output logic convSampleStart,
   output logic convClkTick,
   output logic conversionDoneFlag,
   output logic doneIrqRequest,
   output logic [4:0] inputChannelBits,
   output logic [1:0] refSelect
);

   // ==========================================================================
   // reset release
   logic rstMeta;
   logic rstN;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstN <= rstMeta;
      end
   end

   // ==========================================================================
   // state and helpers
   adc_ctrl_pkg::ctrl_state_s st_ff;
   adc_ctrl_pkg::ctrl_state_s nxt_st;
   logic trigPulse;
   logic wrA;
   logic wrB;
   logic wrMux;
   logic wrDis;
   logic rdLow;
   logic rdHigh;
   logic startReq;
   logic autoStart;
   logic convEnd;
   logic [4:0] convLen;

   // result bytes are formatted at read time from the raw value
   function automatic logic [7:0] resultByte(input logic [9:0] r,
                                             input logic left,
                                             input logic high);
      logic [7:0] b;
      if (left) begin
         b = high ? r[9:2] : {r[1:0], 6'h00};
      end else begin
         b = high ? {6'h00, r[9:8]} : r[7:0];
      end
      return b;
   endfunction

   adc_clk_divider u_div (
      .sys_clk(sys_clk),
      .rstN(rstN),
      .run(st_ff.converterEnable),
      .divideSelect(st_ff.clockDivideSelect),
      .convClkTick(convClkTick)
   );

   adc_trig_edge u_trig (
      .sys_clk(sys_clk),
      .rstN(rstN),
      .autoTriggerEnable(st_ff.autoTriggerEnable),
      .triggerSourceSelect(st_ff.triggerSourceSelect),
      .trigFlags(trigFlags),
      .doneFlag(st_ff.conversionDoneFlag),
      .trigPulse(trigPulse)
   );

   // ==========================================================================
   // register access and conversion sequencing
   always_comb begin
      nxt_st = st_ff;
      nxt_st.convStartPulse = 1'b0;
      nxt_st.rdData = `REG_RESET_VALUE;
      wrA = regWr && (regAddr == `OFS_CTRL_STATUS_A);
      wrB = regWr && (regAddr == `OFS_CTRL_STATUS_B);
      wrMux = regWr && (regAddr == `OFS_CHANNEL_SELECT);
      wrDis = regWr && (regAddr == `OFS_PIN_DISABLE);
      rdLow = regRd && (regAddr == `OFS_RESULT_LOW);
      rdHigh = regRd && (regAddr == `OFS_RESULT_HIGH);
      startReq = 1'b0;
      convLen = st_ff.firstPending ? `FIRST_CONV_CLKS
                                   : `NORMAL_CONV_CLKS;
      convEnd = (st_ff.convState == adc_ctrl_pkg::CONV_RUN) &&
                st_ff.converterEnable && convClkTick &&
                (st_ff.convClkCount == convLen - 5'd1);

      if (wrA) begin
         nxt_st.converterEnable = regWrData[`CSA_ENABLE_BIT];
         nxt_st.autoTriggerEnable = regWrData[`CSA_AUTO_TRIG_BIT];
         nxt_st.doneIrqEnable = regWrData[`CSA_IRQ_ENABLE_BIT];
         nxt_st.clockDivideSelect = regWrData[2:0];
         if (regWrData[`CSA_DONE_FLAG_BIT]) begin
            nxt_st.conversionDoneFlag = 1'b0;
         end
         if (regWrData[`CSA_ENABLE_BIT] && !st_ff.converterEnable) begin
            nxt_st.firstPending = 1'b1;
         end
         // writing zero to start has no effect
         startReq = regWrData[`CSA_START_BIT] && regWrData[`CSA_ENABLE_BIT];
      end
      if (vectorAck) begin
         nxt_st.conversionDoneFlag = 1'b0;
      end
      if (wrB) begin
         // only the select field is stored; bit 7 reads back as zero
         nxt_st.triggerSourceSelect =
            adc_ctrl_pkg::trig_src_e'(regWrData[2:0]);
      end
      if (wrMux) begin
         nxt_st.refSelect = regWrData[7:6];
         nxt_st.leftAlignSelect = regWrData[`CHS_LEFT_ALIGN_BIT];
         nxt_st.inputChannelBits = regWrData[4:0];
      end
      if (wrDis) begin
         nxt_st.pinInputDisableBits = regWrData;
      end

      // low read locks the pair; high read releases it
      if (rdLow) begin
         nxt_st.readLock = 1'b1;
      end
      if (rdHigh) begin
         nxt_st.readLock = 1'b0;
      end

      autoStart = st_ff.autoTriggerEnable && st_ff.converterEnable &&
                  trigPulse;

      unique case (st_ff.convState)
         adc_ctrl_pkg::CONV_IDLE: begin
            if ((startReq || autoStart) && nxt_st.converterEnable) begin
               nxt_st.convState = adc_ctrl_pkg::CONV_RUN;
               nxt_st.convClkCount = 5'd0;
               nxt_st.convStartPulse = 1'b1;
            end
         end
         adc_ctrl_pkg::CONV_RUN: begin
            if (!nxt_st.converterEnable) begin
               // turning the converter off abandons the conversion
               nxt_st.convState = adc_ctrl_pkg::CONV_IDLE;
            end else if (convEnd) begin
               nxt_st.convState = adc_ctrl_pkg::CONV_IDLE;
               nxt_st.firstPending = 1'b0;
               // a result finished while locked is dropped, not queued
               if (!nxt_st.readLock) begin
                  nxt_st.conversionResult = sampleData;
               end
               // set is applied last so it wins over a same-cycle clear
               nxt_st.conversionDoneFlag = 1'b1;
            end else if (convClkTick) begin
               nxt_st.convClkCount = st_ff.convClkCount + 5'd1;
            end
         end
      endcase

      // result bytes have no write path
      if (rdLow || rdHigh) begin
         nxt_st.rdData = resultByte(st_ff.conversionResult,
                                    st_ff.leftAlignSelect,
                                    rdHigh);
      end else if (regRd && regAddr == `OFS_CTRL_STATUS_A) begin
         nxt_st.rdData = {st_ff.converterEnable,
                          st_ff.convState == adc_ctrl_pkg::CONV_RUN,
                          st_ff.autoTriggerEnable, st_ff.conversionDoneFlag,
                          st_ff.doneIrqEnable,
                          st_ff.clockDivideSelect};
      end else if (regRd && regAddr == `OFS_CTRL_STATUS_B) begin
         nxt_st.rdData = {5'h00, st_ff.triggerSourceSelect};
      end else if (regRd && regAddr == `OFS_CHANNEL_SELECT) begin
         nxt_st.rdData = {st_ff.refSelect, st_ff.leftAlignSelect,
                          st_ff.inputChannelBits};
      end else if (regRd && regAddr == `OFS_PIN_DISABLE) begin
         nxt_st.rdData = st_ff.pinInputDisableBits;
      end

      nxt_st.pinRead = pinLevel & ~nxt_st.pinInputDisableBits;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstN) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================================
   // outputs
   assign regRdData = st_ff.rdData;
   assign pinRead = st_ff.pinRead;
   assign inputBufferOff = st_ff.pinInputDisableBits;
   assign convBusy = (st_ff.convState == adc_ctrl_pkg::CONV_RUN);
   assign convSampleStart = st_ff.convStartPulse;
   assign conversionDoneFlag = st_ff.conversionDoneFlag;
   assign doneIrqRequest = st_ff.conversionDoneFlag && st_ff.doneIrqEnable;
   assign inputChannelBits = st_ff.inputChannelBits;
   assign refSelect = st_ff.refSelect;

   // ==========================================================================
   // checks
   property p_right_align;
      @(posedge sys_clk) disable iff (!rstN)
      (rdHigh && !st_ff.leftAlignSelect) |=>
      regRdData == {6'h00, $past(st_ff.conversionResult[9:8])};
   endproperty
   a_right_align: assert property (p_right_align)
      else $error("right aligned high byte wrong");

   property p_left_low;
      @(posedge sys_clk) disable iff (!rstN)
      (rdLow && st_ff.leftAlignSelect) |=>
      regRdData == {$past(st_ff.conversionResult[1:0]), 6'h00};
   endproperty
   a_left_low: assert property (p_left_low)
      else $error("left aligned low byte wrong");

   property p_capture;
      @(posedge sys_clk) disable iff (!rstN)
      (convEnd && !nxt_st.readLock && nxt_st.converterEnable) |=>
      st_ff.conversionResult == $past(sampleData);
   endproperty
   a_capture: assert property (p_capture)
      else $error("completed result not stored");

   property p_lock;
      @(posedge sys_clk) disable iff (!rstN)
      (st_ff.readLock && !rdHigh) |=> $stable(st_ff.conversionResult);
   endproperty
   a_lock: assert property (p_lock)
      else $error("result changed while locked");

   property p_done_set;
      @(posedge sys_clk) disable iff (!rstN)
      (convEnd && nxt_st.converterEnable) |=> conversionDoneFlag;
   endproperty
   a_done_set: assert property (p_done_set)
      else $error("done flag not set at completion");

   property p_start_busy;
      @(posedge sys_clk) disable iff (!rstN)
      (!convBusy && wrA && regWrData[`CSA_ENABLE_BIT] &&
       regWrData[`CSA_START_BIT]) |=> convBusy ##0 convSampleStart;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("start request did not begin a conversion");

   property p_pin_blank;
      @(posedge sys_clk) disable iff (!rstN)
      ##1 1'b1 |-> (inputBufferOff & pinRead) == 8'h00;
   endproperty
   a_pin_blank: assert property (p_pin_blank)
      else $error("disabled pin read not zero");

   property p_vector_clear;
      @(posedge sys_clk) disable iff (!rstN)
      (vectorAck && !convEnd) |=> !conversionDoneFlag;
   endproperty
   a_vector_clear: assert property (p_vector_clear)
      else $error("vector entry did not clear done flag");

   property p_left_high;
      @(posedge sys_clk) disable iff (!rstN)
      (rdHigh && st_ff.leftAlignSelect) |=>
      regRdData == $past(st_ff.conversionResult[9:2]);
   endproperty
   a_left_high: assert property (p_left_high)
      else $error("left aligned high byte wrong");

endmodule
`default_nettype wire

// >>> rtl/adc_ctrl_params.svh
// offsets, field positions, reset values and conversion counts
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// ==========================================================================
// register offsets
`define OFS_RESULT_LOW 8'h78
`define OFS_RESULT_HIGH 8'h79
`define OFS_CTRL_STATUS_A 8'h7a
`define OFS_CTRL_STATUS_B 8'h7b
`define OFS_CHANNEL_SELECT 8'h7c
`define OFS_PIN_DISABLE 8'h7e

// ==========================================================================
// field positions
`define CSA_ENABLE_BIT 7
`define CSA_START_BIT 6
`define CSA_AUTO_TRIG_BIT 5
`define CSA_DONE_FLAG_BIT 4
`define CSA_IRQ_ENABLE_BIT 3
`define CHS_LEFT_ALIGN_BIT 5

// ==========================================================================
// reset values and conversion lengths in converter clocks
`define REG_RESET_VALUE 8'h00
`define FIRST_CONV_CLKS 5'd25
`define NORMAL_CONV_CLKS 5'd13

`endif

// >>> rtl/adc_ctrl_pkg.sv
// types shared by the converter control block
package adc_ctrl_pkg;

   // ==========================================================================
   // trigger sources, in select-code order
   typedef enum logic [2:0] {
      TRIG_FREE_RUN,
      TRIG_COMPARATOR,
      TRIG_EXT_INT0,
      TRIG_T0_COMPARE_A,
      TRIG_T0_OVERFLOW,
      TRIG_T1_COMPARE_B,
      TRIG_T1_OVERFLOW,
      TRIG_T1_CAPTURE
   } trig_src_e;

   typedef struct packed {
      logic t1Capture;
      logic t1Overflow;
      logic t1CompareB;
      logic t0Overflow;
      logic t0CompareA;
      logic extInt0;
      logic comparator;
   } trig_flags_s;

   typedef enum logic {CONV_IDLE, CONV_RUN} conv_state_e;

   // ==========================================================================
   // module state records
   typedef struct packed {
      logic [6:0] count;
      logic tick;
   } div_state_s;

   typedef struct packed {
      logic prevLevel;
      trig_src_e prevSel;
      logic pulse;
   } trig_state_s;

   typedef struct packed {
      conv_state_e convState;
      logic converterEnable;
      logic autoTriggerEnable;
      logic conversionDoneFlag;
      logic doneIrqEnable;
      logic [2:0] clockDivideSelect;
      trig_src_e triggerSourceSelect;
      logic [1:0] refSelect;
      logic leftAlignSelect;
      logic [4:0] inputChannelBits;
      logic [7:0] pinInputDisableBits;
      logic firstPending;
      logic [4:0] convClkCount;
      logic [9:0] conversionResult;
      logic readLock;
      logic [7:0] rdData;
      logic [7:0] pinRead;
      logic convStartPulse;
   } ctrl_state_s;

endpackage

// >>> rtl/adc_clk_divider.sv
// converter clock divider producing a one-cycle tick
`timescale 1ns/10ps
`default_nettype none
module adc_clk_divider (
   input wire logic sys_clk,
   input wire logic rstN,
   input wire logic run,
   input wire logic [2:0] divideSelect,
   output logic convClkTick
);

   adc_ctrl_pkg::div_state_s st_ff;
   adc_ctrl_pkg::div_state_s nxt_st;
   logic [6:0] mask;

   // codes 0 and 1 both give two; the rest give two to the power of code
   function automatic logic [6:0] divMask(input logic [2:0] sel);
      logic [7:0] m;
      m = (8'h01 << sel) - 8'h01;
      if (sel == 3'h0) begin
         m = 8'h01;
      end
      return m[6:0];
   endfunction

   always_comb begin
      nxt_st = st_ff;
      mask = divMask(divideSelect);
      // counter held at zero while off so the first tick is a full period
      nxt_st.count = run ? st_ff.count + 7'h01 : 7'h00;
      nxt_st.tick = run && ((st_ff.count & mask) == mask);
   end

   always_ff @(posedge sys_clk) begin
      if (!rstN) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign convClkTick = st_ff.tick;

   property p_div_four;
      @(posedge sys_clk) disable iff (!rstN)
      (run && divideSelect == 3'h2)[*6] ##1
      (run && divideSelect == 3'h2 && st_ff.tick) |-> $past(st_ff.tick, 4);
   endproperty
   a_div_four: assert property (p_div_four)
      else $error("divide by four tick spacing wrong");

endmodule
`default_nettype wire

// >>> rtl/adc_trig_edge.sv
// trigger source selection and rising edge detection
`timescale 1ns/10ps
`default_nettype none
module adc_trig_edge (
   input wire logic sys_clk,
   input wire logic rstN,
   input wire logic autoTriggerEnable,
   input wire adc_ctrl_pkg::trig_src_e triggerSourceSelect,
   input wire adc_ctrl_pkg::trig_flags_s trigFlags,
   input wire logic doneFlag,
   output logic trigPulse
);

   adc_ctrl_pkg::trig_state_s st_ff;
   adc_ctrl_pkg::trig_state_s nxt_st;
   logic level;
   logic toFreeRun;

   always_comb begin
      nxt_st = st_ff;
      unique case (triggerSourceSelect)
         adc_ctrl_pkg::TRIG_FREE_RUN: level = doneFlag;
         adc_ctrl_pkg::TRIG_COMPARATOR: level = trigFlags.comparator;
         adc_ctrl_pkg::TRIG_EXT_INT0: level = trigFlags.extInt0;
         adc_ctrl_pkg::TRIG_T0_COMPARE_A: level = trigFlags.t0CompareA;
         adc_ctrl_pkg::TRIG_T0_OVERFLOW: level = trigFlags.t0Overflow;
         adc_ctrl_pkg::TRIG_T1_COMPARE_B: level = trigFlags.t1CompareB;
         adc_ctrl_pkg::TRIG_T1_OVERFLOW: level = trigFlags.t1Overflow;
         adc_ctrl_pkg::TRIG_T1_CAPTURE: level = trigFlags.t1Capture;
      endcase
      toFreeRun = (triggerSourceSelect == adc_ctrl_pkg::TRIG_FREE_RUN) &&
                  (st_ff.prevSel != adc_ctrl_pkg::TRIG_FREE_RUN);
      // edge is taken on the muxed level, so a source switch can create one
      nxt_st.prevLevel = level;
      nxt_st.prevSel = triggerSourceSelect;
      nxt_st.pulse = autoTriggerEnable && level && !st_ff.prevLevel &&
                     !toFreeRun;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstN) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign trigPulse = st_ff.pulse;

   property p_free_switch;
      @(posedge sys_clk) disable iff (!rstN)
      toFreeRun |=> !trigPulse;
   endproperty
   a_free_switch: assert property (p_free_switch)
      else $error("switch to free running made a trigger");

   property p_auto_off;
      @(posedge sys_clk) disable iff (!rstN)
      !autoTriggerEnable |=> !trigPulse;
   endproperty
   a_auto_off: assert property (p_auto_off)
      else $error("trigger without auto trigger enable");

endmodule
`default_nettype wire

// >>> tb/trig_flag_model.sv
// peripheral trigger flags and converter sample word seen by the block
`timescale 1ns/10ps
`default_nettype none
module trig_flag_model (
   input wire logic sys_clk,
   input wire logic [6:0] flagTarget,
   input wire logic [3:0] lagCycles,
   input wire logic [9:0] sampleWord,
   output adc_ctrl_pkg::trig_flags_s trigFlags,
   output logic [9:0] sampleData
);
   logic [3:0] waitCnt;

   initial begin
      trigFlags = '0;
      waitCnt = 4'h0;
   end

   // ==========================================================================
   // flag levels
   // a flag follows its source only after the lag, as a slow peripheral would
   always @(posedge sys_clk) begin
      if (trigFlags === flagTarget) begin
         waitCnt <= 4'h0;
      end else if (waitCnt >= lagCycles) begin
         trigFlags <= flagTarget;
         waitCnt <= 4'h0;
      end else begin
         waitCnt <= waitCnt + 4'h1;
      end
   end

   assign sampleData = sampleWord;
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the converter control block
`include "adc_ctrl_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] expVal;
   } reg_row_s;

   logic sys_clk, resetn, regWr, regRd, vectorAck;
   logic [7:0] regAddr, regWrData, regRdData, pinLevel, pinRead, inputBufferOff;
   logic convBusy, convClkTick, conversionDoneFlag, doneIrqRequest;
   logic convSampleStart;
   logic [6:0] flagTarget;
   logic [3:0] lagCycles;
   logic [9:0] sampleWord, sampleData;
   adc_ctrl_pkg::trig_flags_s trigFlags;
   int fails = 0;
   int totalChecks = 0;
   // bit 7 of control b is always written zero
   // pins not read digitally get their input buffers turned off
   reg_row_s rows [6] = '{'{`OFS_CTRL_STATUS_B, 8'h07, 8'h07},
      '{`OFS_PIN_DISABLE, 8'ha5, 8'ha5}, '{`OFS_CHANNEL_SELECT, 8'hc5, 8'hc5},
      '{`OFS_RESULT_LOW, 8'hff, 8'h00}, '{`OFS_RESULT_HIGH, 8'hff, 8'h00},
      '{8'h7d, 8'h5a, 8'h00}};

   adc_ctrl_top i_dut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .sampleData(sampleData), .trigFlags(trigFlags),
      .vectorAck(vectorAck), .pinLevel(pinLevel), .pinRead(pinRead),
      .inputBufferOff(inputBufferOff), .convBusy(convBusy),
      .convSampleStart(convSampleStart), .convClkTick(convClkTick),
      .conversionDoneFlag(conversionDoneFlag),
      .doneIrqRequest(doneIrqRequest), .inputChannelBits(), .refSelect());

   trig_flag_model i_flags (.sys_clk(sys_clk), .flagTarget(flagTarget),
      .lagCycles(lagCycles), .sampleWord(sampleWord), .trigFlags(trigFlags),
      .sampleData(sampleData));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ==========================================================================
   // shared tasks
   task automatic check(input string name, input logic [15:0] expVal,
         input logic [15:0] seen);
      totalChecks++;
      if (seen !== expVal) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, expVal, seen);
      end
   endtask

   task automatic finish_test();
      if (fails == 0 && totalChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rdReg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask

   task automatic waitDone(output int ticks);
      int n;
      ticks = 0;
      // step off the edge so the first busy cycle is counted as well
      #1;
      for (n = 0; n < 2000 && conversionDoneFlag !== 1'b1; n++) begin
         if (convClkTick === 1'b1 && convBusy === 1'b1) ticks++;
         @(posedge sys_clk);
         #1;
      end
      if (n >= 2000) begin
         fails++;
         finish_test();
      end
   endtask

   task automatic waitBusy(input int lim, output logic seen);
      seen = 1'b0;
      for (int n = 0; n < lim && seen !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
         seen = convBusy;
      end
   endtask

   // starts measuring on a tick so a stale phase after a change is skipped
   task automatic tickGap(output int gap);
      for (int n = 0; n < 300 && convClkTick !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
      end
      for (gap = 1; gap < 300; gap++) begin
         @(posedge sys_clk);
         #1;
         if (convClkTick === 1'b1) break;
      end
   endtask

   // ==========================================================================
   // main sequence
   initial begin
      int g, t;
      logic b;
      logic [7:0] d;
      resetn = 1'b0;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      vectorAck = 1'b0;
      pinLevel = 8'hff;
      flagTarget = 7'h00;
      lagCycles = 4'h0;
      sampleWord = 10'h2c7;
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      foreach (rows[i]) begin
         rdReg(rows[i].addr, d);
         check("reset value", 16'h0000, 16'(d));
         wrReg(rows[i].addr, rows[i].wdata);
         rdReg(rows[i].addr, d);
         check("readback", 16'(rows[i].expVal), 16'(d));
      end
      check("pin read", 16'h005a, 16'(pinRead));
      check("buffer off", 16'h00a5, 16'(inputBufferOff));
      wrReg(`OFS_CHANNEL_SELECT, 8'h00);
      wrReg(`OFS_CTRL_STATUS_B, 8'h00);
      for (int c = 0; c < 8; c++) begin
         wrReg(`OFS_CTRL_STATUS_A, 8'h80 | 8'(c));
         tickGap(g);
         tickGap(g);
         check("divide", c ? 16'h1 << c : 16'h2, 16'(g));
      end
      wrReg(`OFS_CTRL_STATUS_A, 8'h00);
      wrReg(`OFS_CTRL_STATUS_A, 8'hc0);
      waitDone(t);
      check("first ticks", 16'h0019, 16'(t));
      rdReg(`OFS_RESULT_LOW, d);
      check("right low", 16'h00c7, 16'(d));
      rdReg(`OFS_RESULT_HIGH, d);
      check("right high", 16'h0002, 16'(d));
      wrReg(`OFS_CHANNEL_SELECT, 8'h20);
      rdReg(`OFS_RESULT_HIGH, d);
      check("left high", 16'h00b1, 16'(d));
      rdReg(`OFS_RESULT_LOW, d);
      check("left low", 16'h00c0, 16'(d));
      check("irq off", 16'h0000, 16'(doneIrqRequest));
      wrReg(`OFS_CTRL_STATUS_A, 8'h98);
      #1;
      check("flag cleared", 16'h0000, 16'(conversionDoneFlag));
      // low byte was read last, so the next result must be held back
      sampleWord = 10'h135;
      wrReg(`OFS_CTRL_STATUS_A, 8'hc8);
      rdReg(`OFS_CTRL_STATUS_A, d);
      check("start bit busy", 16'h0001, 16'(d[6]));
      waitDone(t);
      check("irq request", 16'h0001, 16'(doneIrqRequest));
      rdReg(`OFS_RESULT_HIGH, d);
      check("locked high", 16'h00b1, 16'(d));
      @(posedge sys_clk);
      vectorAck <= 1'b1;
      @(posedge sys_clk);
      vectorAck <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("vector clear", 16'h0000, 16'(conversionDoneFlag));
      wrReg(`OFS_CTRL_STATUS_A, 8'hc8);
      #1;
      check("sample start", 16'h0001, 16'(convSampleStart));
      waitDone(t);
      check("later ticks", 16'h000d, 16'(t));
      rdReg(`OFS_RESULT_LOW, d);
      check("new low", 16'h0040, 16'(d));
      rdReg(`OFS_RESULT_HIGH, d);
      check("new high", 16'h004d, 16'(d));
      wrReg(`OFS_CTRL_STATUS_A, 8'h98);
      wrReg(`OFS_CTRL_STATUS_B, 8'h01);
      flagTarget <= 7'h01;
      waitBusy(10, b);
      check("select ignored", 16'h0000, 16'(b));
      flagTarget <= 7'h00;
      repeat (4) @(posedge sys_clk);
      wrReg(`OFS_CTRL_STATUS_A, 8'hb8);
      for (int c = 1; c < 8; c++) begin
         wrReg(`OFS_CTRL_STATUS_B, 8'(c));
         lagCycles <= 4'(c);
         flagTarget <= 7'h01 << (c - 1);
         waitBusy(40, b);
         check("auto run", 16'h0001, 16'(b));
         waitDone(t);
         wrReg(`OFS_CTRL_STATUS_A, 8'hb8);
         flagTarget <= 7'h00;
         repeat (c + 4) @(posedge sys_clk);
      end
      lagCycles <= 4'h0;
      wrReg(`OFS_CTRL_STATUS_B, 8'h01);
      flagTarget <= 7'h02;
      waitBusy(6, b);
      check("other flag", 16'h0000, 16'(b));
      wrReg(`OFS_CTRL_STATUS_B, 8'h02);
      waitBusy(8, b);
      check("switch edge", 16'h0001, 16'(b));
      waitDone(t);
      flagTarget <= 7'h00;
      wrReg(`OFS_CTRL_STATUS_B, 8'h00);
      waitBusy(10, b);
      check("free run switch", 16'h0000, 16'(b));
      resetn <= 1'b0;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rdReg(`OFS_CTRL_STATUS_A, d);
      check("reset control", 16'h0000, 16'(d));
      rdReg(`OFS_PIN_DISABLE, d);
      check("reset disable", 16'h0000, 16'(d));
      finish_test();
   end
endmodule
`default_nettype wire
